// file: design/otp_lock_pkg.sv
// shared constants, opcode decode and event carrier of the otp lock control
package otp_lock_pkg;
    // instruction opcodes
    localparam logic [7:0] OP_READ_SEC = 8'h2B;
    localparam logic [7:0] OP_WRITE_SEC = 8'h2F;
    localparam logic [7:0] OP_OTP_ENTER = 8'hB1;
    localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
    localparam logic [7:0] OP_WRITE_SR2 = 8'h31;

    // security register layout
    localparam int SEC_FACTORY_BIT = 0;
    localparam int SEC_CUST_BIT = 1;
    localparam logic [5:0] SEC_RESERVED_VAL = 6'h00;

    // otp address map
    localparam logic [23:0] OTP_SN_LAST = 24'h00000F;
    localparam logic [23:0] OTP_LAST = 24'h0001FF;
    localparam logic [1:0] ADDR_LAST_IDX = 2'h2;

    // power-up write inhibit
    localparam int CLK_HZ = 10_000_000;
    localparam int PUW_MIN_MS = 1;
    localparam int PUW_MAX_MS = 10;
    localparam int PUW_CYCLES = (PUW_MIN_MS * CLK_HZ + 999) / 1000;

    typedef enum logic [2:0] {
        CLS_OTHER,
        CLS_ARRAY_WR,
        CLS_ARRAY_WR_NOADDR,
        CLS_STATUS_WR,
        CLS_SEC_WR,
        CLS_SEC_RD,
        CLS_OTP_ENTER,
        CLS_OTP_EXIT
    } op_class_e;

    // events from the serial front end; byte_valid, sck_fall and cs_end last one clk_sys cycle each
    typedef struct packed {
        logic byte_valid;
        logic [7:0] rx_byte;
        logic sck_fall;
        logic cs_end;
        logic active;
        logic aligned;
    } spi_evt_s;

    function automatic op_class_e classify(input logic [7:0] op);
        case (op)
            OP_PAGE_PROG, OP_QUAD_PROG, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K:
                classify = CLS_ARRAY_WR;
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: classify = CLS_ARRAY_WR_NOADDR;
            OP_WRITE_SR1, OP_WRITE_SR2: classify = CLS_STATUS_WR;
            OP_WRITE_SEC: classify = CLS_SEC_WR;
            OP_READ_SEC: classify = CLS_SEC_RD;
            OP_OTP_ENTER: classify = CLS_OTP_ENTER;
            OP_OTP_EXIT: classify = CLS_OTP_EXIT;
            default: classify = CLS_OTHER;
        endcase
    endfunction
endpackage

// file: design/spi_byte_rx.sv
// synchronised spi mode 0 front end: edges, byte assembly, frame end
module spi_byte_rx
    import otp_lock_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    // events
    output spi_evt_s evt
);
    logic [2:0] sck_q, next_sck_q;
    logic [2:0] cs_q, next_cs_q;
    logic [1:0] mosi_q, next_mosi_q;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic sck_rise;

    // stage 0 feeds stage 1 only; edges look at stages 1 and 2
    always_comb begin
        next_sck_q = {sck_q[1:0], sck};
        next_cs_q = {cs_q[1:0], cs_n};
        next_mosi_q = {mosi_q[0], mosi};
        sck_rise = sck_q[1] & ~sck_q[2] & ~cs_q[1];
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        if (cs_q[1]) begin
            next_bit_cnt = 3'h0;
        end else if (sck_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_shreg = {shreg[6:0], mosi_q[1]};
        end
        evt.byte_valid = sck_rise & (bit_cnt == 3'h7);
        evt.rx_byte = {shreg[6:0], mosi_q[1]};
        evt.sck_fall = ~sck_q[1] & sck_q[2] & ~cs_q[1];
        evt.cs_end = cs_q[1] & ~cs_q[2];
        evt.active = ~cs_q[1];
        evt.aligned = (bit_cnt == 3'h0); // R7
    end

    // pins idle high for chip select so reset does not fake a frame end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sck_q <= 3'h0;
            cs_q <= 3'h7;
            mosi_q <= 2'h0;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
        end else begin
            sck_q <= next_sck_q;
            cs_q <= next_cs_q;
            mosi_q <= next_mosi_q;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
        end
    end
endmodule

// file: design/secured_otp_lock_control.sv
// otp mode, security register and write gating of the serial flash
// How it works
// (R1) security register read answers always, busy or not, repeating while clocks run
// (R2) bit 0 reports factory lock: 0 unlocked, 1 locked, non-volatile
// (R3) security register write changes only bit 1, the customer lock bit
// (R4) with customer lock set, otp program, erase and lock changes are refused
// (R5) in otp mode, main array write instructions are ignored
// (R6) security register write needs no prior write enable
// (R7) frames ending off a byte boundary are discarded unexecuted
// (R8) host programs otp by entry command, page program, exit command
// (R9) otp addresses 0 to F are serial number, 10 to 1FF general area
// (R10) writes are ignored during the power-up delay; host waits the maximum
// (R11) opcode B1h enters otp mode, C1h returns to array mode
// (R12) in otp mode, status register and security register writes are rejected
// (R13) locked otp mode accepts read-type commands only; exit C1h is still executed here
module secured_otp_lock_control
    import otp_lock_pkg::*;
#(
    parameter int POWERUP_CYCLES = PUW_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe_n,
    // non-volatile lock cells
    input wire logic factory_lock_cell,
    input wire logic customer_lock_cell,
    output logic lock_program_go,
    // grants to the array and status logic
    output logic mem_write_go,
    output logic otp_write_go,
    output logic status_write_go,
    output logic cmd_refused,
    // state
    output logic otp_mode,
    output logic factory_lock,
    output logic customer_lock,
    output logic powerup_done,
    output logic otp_sn_area,
    output logic otp_gen_area
);
    localparam int PUW_W = $clog2(POWERUP_CYCLES + 1);

    // a zero delay would leave writes open from the first edge after reset
    if (POWERUP_CYCLES < 1) begin : g_bad_delay
        $error("POWERUP_CYCLES must be at least one");
    end

    typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_READSEC, ST_SKIP} frame_e;

    spi_evt_s evt;
    frame_e state, next_state;
    op_class_e op_cls, next_op_cls;
    logic [1:0] addr_idx, next_addr_idx;
    logic [23:0] addr, next_addr;
    logic addr_full, next_addr_full;
    logic data_seen, next_data_seen;
    logic [7:0] sec_data, next_sec_data;
    logic [7:0] sec_sh, next_sec_sh;
    logic next_miso, next_miso_oe_n;
    logic next_otp_mode, next_mem_go, next_otp_go, next_status_go;
    logic next_lock_go, next_refused, next_sn, next_gen;
    logic cust_shadow, next_cust_shadow;
    logic [1:0] fl_q, next_fl_q;
    logic [1:0] cl_q, next_cl_q;
    logic next_factory_lock, next_customer_lock;
    logic [PUW_W-1:0] puw_cnt, next_puw_cnt;
    logic next_powerup_done;
    logic otp_locked;

    spi_byte_rx u_rx (
        .clk_sys(clk_sys),
        .srst(srst),
        .sck(sck),
        .cs_n(cs_n),
        .mosi(mosi),
        .evt(evt)
    );

    // power-up write inhibit counter; the shortest delay is used, host waits the longest
    always_comb begin
        next_puw_cnt = puw_cnt;
        next_powerup_done = powerup_done;
        if (puw_cnt == PUW_W'(POWERUP_CYCLES)) begin
            next_powerup_done = 1'b1; // R10
        end else begin
            next_puw_cnt = puw_cnt + PUW_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            puw_cnt <= '0;
            powerup_done <= 1'b0;
        end else begin
            puw_cnt <= next_puw_cnt;
            powerup_done <= next_powerup_done;
        end
    end

    // lock cells are foreign levels: two flops each, then the lock view
    always_comb begin
        next_fl_q = {fl_q[0], factory_lock_cell};
        next_cl_q = {cl_q[0], customer_lock_cell};
        next_factory_lock = fl_q[1]; // R2
        // shadow keeps the lock visible before the cell reports the new value
        next_customer_lock = cl_q[1] | cust_shadow;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fl_q <= 2'h0;
            cl_q <= 2'h0;
            factory_lock <= 1'b0;
            customer_lock <= 1'b0;
        end else begin
            fl_q <= next_fl_q;
            cl_q <= next_cl_q;
            factory_lock <= next_factory_lock;
            customer_lock <= next_customer_lock;
        end
    end

    assign otp_locked = factory_lock | customer_lock;

    // frame decoder, security register shifter and end-of-frame decisions
    always_comb begin
        next_state = state;
        next_op_cls = op_cls;
        next_addr_idx = addr_idx;
        next_addr = addr;
        next_addr_full = addr_full;
        next_data_seen = data_seen;
        next_sec_data = sec_data;
        next_sec_sh = sec_sh;
        next_miso = miso;
        next_miso_oe_n = 1'b1;
        next_otp_mode = otp_mode;
        next_mem_go = 1'b0;
        next_otp_go = 1'b0;
        next_status_go = 1'b0;
        next_lock_go = 1'b0;
        next_refused = 1'b0;
        next_sn = otp_sn_area;
        next_gen = otp_gen_area;
        next_cust_shadow = cust_shadow;

        if (evt.active && evt.byte_valid) begin
            case (state)
                ST_OPCODE: begin
                    next_op_cls = classify(evt.rx_byte);
                    next_addr_idx = 2'h0;
                    next_addr_full = 1'b0;
                    next_data_seen = 1'b0;
                    case (classify(evt.rx_byte))
                        CLS_ARRAY_WR: next_state = ST_ADDR;
                        CLS_SEC_WR: next_state = ST_DATA;
                        CLS_SEC_RD: begin
                            // value taken now; bits 7:2 read as zero
                            next_sec_sh = {SEC_RESERVED_VAL, customer_lock, factory_lock};
                            next_state = ST_READSEC; // R1
                        end
                        default: next_state = ST_SKIP;
                    endcase
                end
                ST_ADDR: begin
                    next_addr = {addr[15:0], evt.rx_byte};
                    next_addr_idx = addr_idx + 2'h1;
                    if (addr_idx == ADDR_LAST_IDX) begin
                        next_addr_full = 1'b1;
                        next_state = ST_SKIP;
                    end
                end
                ST_DATA: begin
                    next_sec_data = evt.rx_byte;
                    next_data_seen = 1'b1;
                    next_state = ST_SKIP;
                end
                ST_READSEC, ST_SKIP: next_state = state;
                default: next_state = ST_SKIP;
            endcase
        end

        // rotate so the register repeats for as long as clocks come
        if (state == ST_READSEC && evt.active) begin
            next_miso_oe_n = 1'b0;
            if (evt.sck_fall) begin
                next_miso = sec_sh[7]; // R1
                next_sec_sh = {sec_sh[6:0], sec_sh[7]};
            end
        end

        if (evt.cs_end) begin
            next_state = ST_OPCODE;
            if (state != ST_OPCODE) begin
                if (!evt.aligned) begin
                    next_refused = (op_cls != CLS_OTHER) && (op_cls != CLS_SEC_RD); // R7
                end else begin
                    case (op_cls)
                        CLS_OTP_ENTER: next_otp_mode = 1'b1; // R11
                        CLS_OTP_EXIT: next_otp_mode = 1'b0; // R11
                        CLS_ARRAY_WR, CLS_ARRAY_WR_NOADDR: begin
                            if (!powerup_done) begin
                                next_refused = 1'b1; // R10
                            end else if (!otp_mode) begin
                                if (op_cls == CLS_ARRAY_WR_NOADDR || addr_full) begin
                                    next_mem_go = 1'b1;
                                end else begin
                                    next_refused = 1'b1;
                                end
                            end else if (otp_locked) begin
                                next_refused = 1'b1; // R4 R13
                            end else if (op_cls == CLS_ARRAY_WR_NOADDR || !addr_full
                                         || addr > OTP_LAST) begin
                                next_refused = 1'b1; // R5
                            end else begin
                                // page program goes to otp, never to the array
                                next_otp_go = 1'b1; // R5 R8
                                next_sn = (addr <= OTP_SN_LAST); // R9
                                next_gen = (addr > OTP_SN_LAST); // R9
                            end
                        end
                        CLS_STATUS_WR: begin
                            if (!powerup_done || otp_mode) begin
                                next_refused = 1'b1; // R10 R12
                            end else begin
                                next_status_go = 1'b1;
                            end
                        end
                        CLS_SEC_WR: begin
                            // no write enable latch is consulted here
                            if (!powerup_done || otp_mode || customer_lock || !data_seen) begin
                                next_refused = 1'b1; // R4 R6 R10 R12
                            end else if (sec_data[SEC_CUST_BIT]) begin
                                next_lock_go = 1'b1; // R3
                                next_cust_shadow = 1'b1; // R3
                            end
                        end
                        default: next_refused = 1'b0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_OPCODE;
            op_cls <= CLS_OTHER;
            addr_idx <= 2'h0;
            addr <= 24'h000000;
            addr_full <= 1'b0;
            data_seen <= 1'b0;
            sec_data <= 8'h00;
            sec_sh <= 8'h00;
            miso <= 1'b0;
            miso_oe_n <= 1'b1;
            otp_mode <= 1'b0;
            mem_write_go <= 1'b0;
            otp_write_go <= 1'b0;
            status_write_go <= 1'b0;
            lock_program_go <= 1'b0;
            cmd_refused <= 1'b0;
            otp_sn_area <= 1'b0;
            otp_gen_area <= 1'b0;
            cust_shadow <= 1'b0;
        end else begin
            state <= next_state;
            op_cls <= next_op_cls;
            addr_idx <= next_addr_idx;
            addr <= next_addr;
            addr_full <= next_addr_full;
            data_seen <= next_data_seen;
            sec_data <= next_sec_data;
            sec_sh <= next_sec_sh;
            miso <= next_miso;
            miso_oe_n <= next_miso_oe_n;
            otp_mode <= next_otp_mode;
            mem_write_go <= next_mem_go;
            otp_write_go <= next_otp_go;
            status_write_go <= next_status_go;
            lock_program_go <= next_lock_go;
            cmd_refused <= next_refused;
            otp_sn_area <= next_sn;
            otp_gen_area <= next_gen;
            cust_shadow <= next_cust_shadow;
        end
    end
endmodule

// file: test/otp_lock_monitor.sv
// port-level assertion checker of the otp lock control
module otp_lock_monitor
    import otp_lock_pkg::*;
#(
    parameter int POWERUP_CYCLES = PUW_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // observed ports
    input wire logic factory_lock_cell,
    input wire logic miso_oe_n,
    input wire logic lock_program_go,
    input wire logic mem_write_go,
    input wire logic otp_write_go,
    input wire logic status_write_go,
    input wire logic otp_mode,
    input wire logic factory_lock,
    input wire logic customer_lock,
    input wire logic powerup_done,
    input wire logic otp_sn_area,
    input wire logic otp_gen_area
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] age;
    logic [15:0] next_age;
    logic grant;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    // cycles since reset; saturates so a long run never wraps under the delay
    always_comb begin
        next_age = (age == 16'hFFFF) ? age : age + 16'h0001;
        if (srst) begin
            next_age = 16'h0000;
        end
    end
    always_ff @(posedge clk_sys) begin
        age <= next_age;
    end
    assign grant = lock_program_go | mem_write_go | otp_write_go | status_write_go;
    // reset leaves the block idle
    a_reset_clears: assert property ($fell(srst) |->
        !otp_mode && miso_oe_n && !powerup_done)
        else $error("state not cleared by reset");
    a_powerup_span: assert property ($rose(powerup_done) |->
        age >= POWERUP_CYCLES && age <= POWERUP_CYCLES + 3)
        else $error("write delay ended at the wrong time");
    a_grant_after_pu: assert property (grant |-> powerup_done)
        else $error("write granted during the power-up delay");
    a_no_array_otp: assert property (mem_write_go |-> !otp_mode && !$past(otp_mode))
        else $error("array write granted in otp mode");
    a_status_outside: assert property (status_write_go |-> !otp_mode && !$past(otp_mode))
        else $error("status write granted in otp mode");
    a_otp_write_open: assert property (otp_write_go |->
        otp_mode && !factory_lock && !customer_lock)
        else $error("otp write granted while locked");
    a_lock_once: assert property (lock_program_go |->
        !$past(customer_lock) && !otp_mode ##1 customer_lock)
        else $error("lock bit set twice or not shown");
    a_area_cause: assert property ($rose(otp_sn_area) || $rose(otp_gen_area) |->
        otp_write_go || $past(otp_write_go))
        else $error("area flag moved without an otp write");
    a_area_single: assert property (!(otp_sn_area && otp_gen_area))
        else $error("both otp areas flagged");
    a_factory_follow: assert property (
        $stable(factory_lock_cell) [*5] ##0 age > 16'h0008 |-> factory_lock == factory_lock_cell)
        else $error("factory lock does not follow its cell");
    c_lock: cover property (lock_program_go);
    c_otp_prog: cover property (otp_write_go);
    c_sec_read: cover property ($fell(miso_oe_n));
endmodule

// file: test/spi_host_model.sv
// serial host controller model: mode 0 frames, msb first
module spi_host_model (
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // slow phases because the device samples the pins through synchronisers
    task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--) begin
            mosi <= d[i];
            repeat (6) @(posedge clk_sys);
            if (miso_oe_n === 1'b0) rd = {rd[6:0], miso};
            sck <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        cs_n <= 1'b1;
        mosi <= ~mosi; // idle line shows no stale bit
        repeat (12) @(posedge clk_sys);
    endtask
endmodule

// file: test/tb_top.sv
// self-checking bench of the otp lock control
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PU = 400;
    typedef struct {
        logic [31:0] d;
        int n;
        logic [4:0] p;
        logic m;
        logic [1:0] a;
        logic [7:0] r;
    } row_s;
    logic clk_sys, srst, factory_lock_cell, customer_lock_cell;
    logic sck, cs_n, mosi, miso, miso_oe_n;
    logic lock_program_go, mem_write_go, otp_write_go, status_write_go, cmd_refused;
    logic otp_mode, factory_lock, customer_lock, powerup_done, otp_sn_area, otp_gen_area;
    logic clr;
    logic [4:0] seen;
    int compares;
    int miscompares;
    row_s rows [37];
    secured_otp_lock_control #(.POWERUP_CYCLES(PU)) dut (
        .clk_sys(clk_sys), .srst(srst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe_n(miso_oe_n), .factory_lock_cell(factory_lock_cell),
        .customer_lock_cell(customer_lock_cell), .lock_program_go(lock_program_go),
        .mem_write_go(mem_write_go), .otp_write_go(otp_write_go),
        .status_write_go(status_write_go), .cmd_refused(cmd_refused), .otp_mode(otp_mode),
        .factory_lock(factory_lock), .customer_lock(customer_lock),
        .powerup_done(powerup_done), .otp_sn_area(otp_sn_area), .otp_gen_area(otp_gen_area)
    );
    spi_host_model host (
        .clk_sys(clk_sys), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n)
    );
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // pulses last one cycle, so gather them over a whole frame
    always @(posedge clk_sys) begin
        seen <= clr ? 5'h00 : (seen | {lock_program_go, mem_write_go, otp_write_go,
            status_write_go, cmd_refused});
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t saw %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic wait_pu();
        for (int k = 0; k < PU + 50 && powerup_done !== 1'b1; k++) @(negedge clk_sys);
        check(32'(powerup_done), 32'h0000_0001);
    endtask
    task automatic run_row(input int i);
        logic [7:0] rd;
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        host.xfer(rows[i].d, rows[i].n, rd);
        @(negedge clk_sys);
        check(32'(seen), 32'(rows[i].p));
        check(32'(otp_mode), 32'(rows[i].m));
        check(32'({otp_sn_area, otp_gen_area}), 32'(rows[i].a));
        if (rows[i].d >> (rows[i].n - 8) == 32'h0000_002B) begin
            check(32'(rd), 32'(rows[i].r));
        end
    endtask
    initial begin
        srst = 1'b1;
        factory_lock_cell = 1'b0;
        customer_lock_cell = 1'b0;
        clr = 1'b0;
        compares = 0;
        miscompares = 0;
        // pulses {lock, array, otp, status, refused}; area {serial number, general}
        rows = '{
            '{32'h2F02, 16, 5'h01, 1'b0, 2'h0, 8'h00},
            '{32'h2B00, 16, 5'h00, 1'b0, 2'h0, 8'h00},
            '{32'h02000100, 32, 5'h08, 1'b0, 2'h0, 8'h00},
            '{32'h0100, 16, 5'h02, 1'b0, 2'h0, 8'h00},
            '{32'h2F01, 16, 5'h00, 1'b0, 2'h0, 8'h00},
            '{32'h1781, 15, 5'h01, 1'b0, 2'h0, 8'h00},
            '{32'hB1, 8, 5'h00, 1'b1, 2'h0, 8'h00},
            '{32'h02000005, 32, 5'h04, 1'b1, 2'h2, 8'h00},
            '{32'h02000010, 32, 5'h04, 1'b1, 2'h1, 8'h00},
            '{32'h02000200, 32, 5'h01, 1'b1, 2'h1, 8'h00},
            '{32'h60, 8, 5'h01, 1'b1, 2'h1, 8'h00},
            '{32'h0100, 16, 5'h01, 1'b1, 2'h1, 8'h00},
            '{32'h2F02, 16, 5'h01, 1'b1, 2'h1, 8'h00},
            '{32'h2B0000, 24, 5'h00, 1'b1, 2'h1, 8'h00},
            '{32'hC1, 8, 5'h00, 1'b0, 2'h1, 8'h00},
            '{32'h2F02, 16, 5'h10, 1'b0, 2'h1, 8'h00},
            '{32'h2B00, 16, 5'h00, 1'b0, 2'h1, 8'h02},
            '{32'h2F02, 16, 5'h01, 1'b0, 2'h1, 8'h00},
            '{32'hB1, 8, 5'h00, 1'b1, 2'h1, 8'h00},
            '{32'h02000020, 32, 5'h01, 1'b1, 2'h1, 8'h00},
            '{32'h2B00, 16, 5'h00, 1'b1, 2'h1, 8'h02},
            '{32'hC1, 8, 5'h00, 1'b0, 2'h1, 8'h00},
            '{32'h02000000, 32, 5'h08, 1'b0, 2'h1, 8'h00},
            '{32'h2B00, 16, 5'h00, 1'b0, 2'h0, 8'h01},
            '{32'hB1, 8, 5'h00, 1'b1, 2'h0, 8'h00},
            '{32'h02000000, 32, 5'h01, 1'b1, 2'h0, 8'h00},
            '{32'hC1, 8, 5'h00, 1'b0, 2'h0, 8'h00},
            '{32'h20001000, 32, 5'h08, 1'b0, 2'h0, 8'h00},
            '{32'h52008000, 32, 5'h08, 1'b0, 2'h0, 8'h00},
            '{32'hD8010000, 32, 5'h08, 1'b0, 2'h0, 8'h00},
            '{32'hC7, 8, 5'h08, 1'b0, 2'h0, 8'h00},
            '{32'h32000000, 32, 5'h08, 1'b0, 2'h0, 8'h00},
            '{32'h3100, 16, 5'h02, 1'b0, 2'h0, 8'h00},
            '{32'h020001, 24, 5'h01, 1'b0, 2'h0, 8'h00},
            '{32'h9F00, 16, 5'h00, 1'b0, 2'h0, 8'h00},
            '{32'h2B00, 16, 5'h00, 1'b0, 2'h0, 8'h03},
            '{32'h2F02, 16, 5'h01, 1'b0, 2'h0, 8'h00}};
        do_reset();
        check(32'(powerup_done), 32'h0000_0000);
        run_row(0);
        check(32'(customer_lock), 32'h0000_0000);
        wait_pu();
        for (int i = 1; i < 23; i++) run_row(i);
        // second power-up with the region locked at the factory
        @(posedge clk_sys);
        factory_lock_cell <= 1'b1;
        do_reset();
        wait_pu();
        check(32'(factory_lock), 32'h0000_0001);
        check(32'(customer_lock), 32'h0000_0000);
        for (int i = 23; i < 35; i++) run_row(i);
        // the cell alone must carry a customer lock; the shadow was cleared by the last reset
        @(posedge clk_sys);
        customer_lock_cell <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(32'(customer_lock), 32'h0000_0001);
        for (int i = 35; i < 37; i++) run_row(i);
        stop_test();
    end
    // the tests need about one millisecond; three cuts short a hang
    initial begin
        #3_000_000;
        miscompares++;
        stop_test();
    end
endmodule
bind secured_otp_lock_control otp_lock_monitor #(.POWERUP_CYCLES(POWERUP_CYCLES)) mon (
    .clk_sys(clk_sys), .srst(srst), .factory_lock_cell(factory_lock_cell),
    .miso_oe_n(miso_oe_n), .lock_program_go(lock_program_go), .mem_write_go(mem_write_go),
    .otp_write_go(otp_write_go), .status_write_go(status_write_go), .otp_mode(otp_mode),
    .factory_lock(factory_lock), .customer_lock(customer_lock), .powerup_done(powerup_done),
    .otp_sn_area(otp_sn_area), .otp_gen_area(otp_gen_area)
);
